//--- design/orlrs_pkg.sv
package orlrs_pkg;
    // one-time-programmable space geometry
    localparam int OTP_BYTES = 1024;
    localparam int OTP_AW = 10;
    localparam int REGION_SHIFT = 5;
    localparam int RANDOM_BYTES = 16;
    localparam logic [OTP_AW-1:0] RANDOM_LIMIT = 10'h010;
    localparam logic [OTP_AW-1:0] LOCK_BASE = 10'h010;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // factory random value; the default is arbitrary and neutral
    localparam logic [127:0] RANDOM_DEFAULT = 128'h0123456789abcdeffedcba9876543210;

    // serial command codes
    localparam logic [7:0] CMD_OTP_READ = 8'h4b;
    localparam logic [7:0] CMD_OTP_PROG = 8'h42;
    localparam logic [7:0] CMD_REG_READ = 8'h65;
    localparam logic [7:0] CMD_REG_WRITE_NV = 8'h71;
    localparam logic [7:0] CMD_REG_WRITE_V = 8'h72;
    localparam logic [7:0] CMD_REG_PROG_OTP = 8'h73;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;
    localparam logic [7:0] CMD_SOFT_RESET = 8'hf0;

    // register indices: pairs first, then one volatile-only register and a fixed status register
    localparam int REG_PAIRS = 6;
    localparam logic [2:0] REG_SR1 = 3'h0;
    localparam logic [2:0] REG_CR1 = 3'h1;
    localparam logic [2:0] REG_CR2 = 3'h2;
    localparam logic [2:0] REG_CR3 = 3'h3;
    localparam logic [2:0] REG_CR4 = 3'h4;
    localparam logic [2:0] REG_DLR = 3'h5;
    localparam logic [2:0] REG_STATUS_TWO_VOLATILE = 3'h6;
    localparam logic [2:0] REG_ERROR_CORRECTION_STATUS = 3'h7;

    // reset and delivery values, field positions
    localparam logic [7:0] NV_DEFAULT = 8'h00;
    localparam logic [7:0] V_RESET = 8'h00;
    localparam logic [7:0] ERROR_CORRECTION_STATUS_VALUE = 8'h00;
    localparam int BIT_PROG_ERR = 6;
    localparam int BIT_FREEZE = 0;

    // serial framing counts
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] ADDR_LAST = 2'h2;
    localparam logic [23:0] ADDR_STEP = 24'h000001;

    typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA, PH_IDLE} orlrs_phase_e;
    typedef logic [7:0] orlrs_byte_t;

    // byte that holds the lock bit of a region
    function automatic logic [OTP_AW-1:0] lock_byte_addr(input logic [4:0] region);
        return LOCK_BASE + {8'h00, region[4:3]};
    endfunction
endpackage

//--- design/orlrs_mem_if.sv
`timescale 1ns/10ps
interface orlrs_mem_if #(
    parameter int AW = 10
);
    logic [AW-1:0] rd_addr;
    logic [7:0] rd_data;
    logic [AW-1:0] lk_addr;
    logic [7:0] lk_data;
    logic prog_en;
    logic [AW-1:0] prog_addr;
    logic [7:0] prog_data;

    modport ctrl (output rd_addr, lk_addr, prog_en, prog_addr, prog_data, input rd_data, lk_data);
    modport store (input rd_addr, lk_addr, prog_en, prog_addr, prog_data, output rd_data, lk_data);
endinterface

//--- design/orlrs_store.sv
`timescale 1ns/10ps
module orlrs_store
    import orlrs_pkg::*;
#(
    parameter int BYTES = OTP_BYTES,
    parameter logic [127:0] RANDOM_VALUE = RANDOM_DEFAULT
) (
    // clock and delivery-state load
    input wire logic clock_in,
    input wire logic factory_n_in,
    // access from the controller
    orlrs_mem_if.store mem
);
    orlrs_byte_t mem_r [BYTES];
    orlrs_byte_t mem_nxt [BYTES];

    // programming only clears bits; an erased one stays where it was
    always_comb begin
        mem_nxt = mem_r;
        if (mem.prog_en) begin
            mem_nxt[mem.prog_addr] = mem_r[mem.prog_addr] & mem.prog_data;
        end
    end

    // factory load gives the delivery image: random value low, all else erased
    always_ff @(posedge clock_in or negedge factory_n_in) begin
        if (!factory_n_in) begin
            // two loops keep every random-value slice inside the 128-bit parameter
            for (int i = 0; i < RANDOM_BYTES; i++) begin
                mem_r[i] <= RANDOM_VALUE[8*i +: 8];
            end
            for (int i = RANDOM_BYTES; i < BYTES; i++) begin
                mem_r[i] <= ERASED_BYTE;
            end
        end else begin
            mem_r <= mem_nxt;
        end
    end

    // two read ports: data path and lock lookup
    assign mem.rd_data = mem_r[mem.rd_addr];
    assign mem.lk_data = mem_r[mem.lk_addr];
endmodule

//--- design/orlrs_device.sv
// How it works
// - separate 1024-byte one-time-programmable space
// - 32 regions of 32 bytes, each lockable
// - random bytes ignore programmed ones, keep value
// - zero into random bytes fails, sets error
// - lock bytes 010-013, bit per region, zero locks
// - locked region refuses every later program
// - lock, reserved and user bytes delivered as FF
// - freeze bit blocks OTP programming only, not register writes; reset reloads it from nv
// - register read returns the volatile version
// - device reset and soft reset copy non-volatile into volatile; the factory load does not
// - non-volatile write rewrites copy, refreshes volatile
// - register program clears nv bits, matching volatile bits
// - volatile write touches only the volatile version
// - volatile-only register defaults after reset, nv from delivery
`timescale 1ns/10ps
module orlrs_device
    import orlrs_pkg::*;
#(
    parameter int BYTES = OTP_BYTES,
    parameter logic [127:0] RANDOM_VALUE = RANDOM_DEFAULT
) (
    // clock and resets
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic factory_n_in,
    // serial link
    input wire logic spi_sck_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_mosi_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    // status
    output logic prog_error_out,
    output logic freeze_out
);
    orlrs_mem_if #(.AW(OTP_AW)) mem ();

    orlrs_store #(
        .BYTES(BYTES),
        .RANDOM_VALUE(RANDOM_VALUE)
    ) u_store (
        .clock_in(clock_in),
        .factory_n_in(factory_n_in),
        .mem(mem.store)
    );

    // link synchronisers; stage three only feeds the edge detector
    logic sck_s1_r, sck_s2_r, sck_s3_r;
    logic cs_n_s1_r, cs_n_s2_r;
    logic mosi_s1_r, mosi_s2_r;

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_s3_r <= 1'b0;
            cs_n_s1_r <= 1'b1;
            cs_n_s2_r <= 1'b1;
            mosi_s1_r <= 1'b0;
            mosi_s2_r <= 1'b0;
        end else begin
            sck_s1_r <= spi_sck_in;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            cs_n_s1_r <= spi_cs_n_in;
            cs_n_s2_r <= cs_n_s1_r;
            mosi_s1_r <= spi_mosi_in;
            mosi_s2_r <= mosi_s1_r;
        end
    end

    logic sck_rise;
    logic sck_fall;
    assign sck_rise = sck_s2_r & ~sck_s3_r;
    assign sck_fall = ~sck_s2_r & sck_s3_r;

    // framing state
    orlrs_phase_e phase_r, phase_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic [1:0] addr_cnt_r, addr_cnt_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic miso_r, miso_nxt;
    logic oe_r, oe_nxt;

    // register state
    orlrs_byte_t nv_r [REG_PAIRS];
    orlrs_byte_t nv_nxt [REG_PAIRS];
    orlrs_byte_t v_r [REG_PAIRS];
    orlrs_byte_t v_nxt [REG_PAIRS];
    orlrs_byte_t status_two_volatile_r, status_two_volatile_nxt;
    logic copy_r, copy_nxt;

    // decoded events shared by both groups
    logic byte_done;
    logic [7:0] byte_val;
    logic data_byte;
    logic soft_reset_req;
    logic clear_req;
    logic is_read_cmd;
    logic [OTP_AW-1:0] otp_addr;
    logic [4:0] region;
    logic region_locked;
    logic in_random;
    logic freeze;
    logic otp_err;
    logic [2:0] reg_idx;
    orlrs_byte_t rd_byte;

    assign byte_done = sck_rise & ~cs_n_s2_r & (bit_cnt_r == BIT_LAST);
    assign byte_val = {rx_r[6:0], mosi_s2_r};
    assign data_byte = byte_done & (phase_r == PH_DATA);
    assign soft_reset_req = byte_done & (phase_r == PH_CMD) & (byte_val == CMD_SOFT_RESET);
    assign clear_req = byte_done & (phase_r == PH_CMD) & (byte_val == CMD_CLEAR_STATUS);
    assign is_read_cmd = (cmd_r == CMD_OTP_READ) | (cmd_r == CMD_REG_READ);
    assign otp_addr = addr_r[OTP_AW-1:0];
    assign reg_idx = addr_r[2:0];

    // region lock lookup: bit clear in the lock bytes means locked
    assign region = otp_addr[OTP_AW-1:REGION_SHIFT];
    assign region_locked = ~mem.lk_data[region[2:0]];
    assign in_random = otp_addr < RANDOM_LIMIT;
    assign freeze = v_r[REG_CR1][BIT_FREEZE];

    // a program byte fails when frozen, locked, or zeroing random bits
    assign otp_err = freeze
        | region_locked
        | (in_random & (byte_val != ERASED_BYTE));

    // programming strobe; random-area ones are accepted but stored nowhere
    assign mem.lk_addr = lock_byte_addr(region);
    assign mem.prog_addr = otp_addr;
    assign mem.prog_data = byte_val;
    assign mem.prog_en = data_byte & (cmd_r == CMD_OTP_PROG) & ~otp_err & ~in_random;
    assign mem.rd_addr = otp_addr;

    // read source; pairs always answer from the volatile copy
    always_comb begin
        rd_byte = ERROR_CORRECTION_STATUS_VALUE;
        if (cmd_r == CMD_OTP_READ) begin
            rd_byte = mem.rd_data;
        end else if (reg_idx < REG_PAIRS) begin
            rd_byte = v_r[reg_idx];
        end else if (reg_idx == REG_STATUS_TWO_VOLATILE) begin
            rd_byte = status_two_volatile_r;
        end
    end

    // serial framing: command, three address bytes, then data
    always_comb begin
        phase_nxt = phase_r;
        cmd_nxt = cmd_r;
        addr_nxt = addr_r;
        bit_cnt_nxt = bit_cnt_r;
        addr_cnt_nxt = addr_cnt_r;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        miso_nxt = miso_r;
        oe_nxt = oe_r;
        if (cs_n_s2_r) begin
            // deselect aborts whatever frame was open
            phase_nxt = PH_CMD;
            bit_cnt_nxt = 3'h0;
            addr_cnt_nxt = 2'h0;
            oe_nxt = 1'b0;
        end else begin
            if (sck_rise) begin
                rx_nxt = byte_val;
                bit_cnt_nxt = bit_cnt_r + 3'h1;
            end
            if (byte_done) begin
                case (phase_r)
                    PH_CMD: begin
                        cmd_nxt = byte_val;
                        addr_cnt_nxt = 2'h0;
                        if ((byte_val == CMD_OTP_READ) || (byte_val == CMD_OTP_PROG) ||
                            (byte_val == CMD_REG_READ) || (byte_val == CMD_REG_WRITE_NV) ||
                            (byte_val == CMD_REG_WRITE_V) || (byte_val == CMD_REG_PROG_OTP)) begin
                            phase_nxt = PH_ADDR;
                        end else begin
                            phase_nxt = PH_IDLE;
                        end
                    end
                    PH_ADDR: begin
                        addr_nxt = {addr_r[15:0], byte_val};
                        addr_cnt_nxt = addr_cnt_r + 2'h1;
                        if (addr_cnt_r == ADDR_LAST) begin
                            phase_nxt = PH_DATA;
                        end
                    end
                    PH_DATA: begin
                        if (!is_read_cmd) begin
                            addr_nxt = addr_r + ADDR_STEP;
                        end
                    end
                    default: begin
                        phase_nxt = PH_IDLE;
                    end
                endcase
            end
            // reads shift out on the falling edge, a fresh byte at each boundary
            if (sck_fall && (phase_r == PH_DATA) && is_read_cmd) begin
                oe_nxt = 1'b1;
                if (bit_cnt_r == 3'h0) begin
                    miso_nxt = rd_byte[7];
                    tx_nxt = {rd_byte[6:0], 1'b0};
                    addr_nxt = addr_r + ADDR_STEP;
                end else begin
                    miso_nxt = tx_r[7];
                    tx_nxt = {tx_r[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_r <= PH_CMD;
            cmd_r <= 8'h00;
            addr_r <= 24'h000000;
            bit_cnt_r <= 3'h0;
            addr_cnt_r <= 2'h0;
            rx_r <= 8'h00;
            tx_r <= 8'h00;
            miso_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            cmd_r <= cmd_nxt;
            addr_r <= addr_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            addr_cnt_r <= addr_cnt_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            miso_r <= miso_nxt;
            oe_r <= oe_nxt;
        end
    end

    // register updates; the error set comes last so it beats any clear
    always_comb begin
        nv_nxt = nv_r;
        v_nxt = v_r;
        status_two_volatile_nxt = status_two_volatile_r;
        copy_nxt = 1'b0;
        if (copy_r) begin
            v_nxt = nv_r;
            status_two_volatile_nxt = V_RESET;
        end
        if (soft_reset_req) begin
            copy_nxt = 1'b1;
        end
        if (clear_req) begin
            v_nxt[REG_SR1][BIT_PROG_ERR] = 1'b0;
        end
        if (data_byte) begin
            case (cmd_r)
                CMD_REG_WRITE_NV: begin
                    if (reg_idx < REG_PAIRS) begin
                        nv_nxt[reg_idx] = byte_val;
                        v_nxt[reg_idx] = byte_val;
                    end
                end
                CMD_REG_PROG_OTP: begin
                    if (reg_idx < REG_PAIRS) begin
                        nv_nxt[reg_idx] = nv_r[reg_idx] & byte_val;
                        v_nxt[reg_idx] = v_r[reg_idx] & byte_val;
                    end
                end
                CMD_REG_WRITE_V: begin
                    if (reg_idx < REG_PAIRS) begin
                        v_nxt[reg_idx] = byte_val;
                    end else if (reg_idx == REG_STATUS_TWO_VOLATILE) begin
                        status_two_volatile_nxt = byte_val;
                    end
                end
                CMD_OTP_PROG: begin
                    if (otp_err) begin
                        v_nxt[REG_SR1][BIT_PROG_ERR] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // volatile copies reset to a constant, then get the copy one cycle later
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < REG_PAIRS; i++) begin
                v_r[i] <= V_RESET;
            end
            status_two_volatile_r <= V_RESET;
            copy_r <= 1'b1;
        end else begin
            v_r <= v_nxt;
            status_two_volatile_r <= status_two_volatile_nxt;
            copy_r <= copy_nxt;
        end
    end

    // non-volatile copies survive device resets; only the factory load clears them
    always_ff @(posedge clock_in or negedge factory_n_in) begin
        if (!factory_n_in) begin
            for (int i = 0; i < REG_PAIRS; i++) begin
                nv_r[i] <= NV_DEFAULT;
            end
        end else begin
            nv_r <= nv_nxt;
        end
    end

    // outputs straight from flip-flops
    assign spi_miso_out = miso_r;
    assign spi_miso_oe_out = oe_r;
    assign prog_error_out = v_r[REG_SR1][BIT_PROG_ERR];
    assign freeze_out = v_r[REG_CR1][BIT_FREEZE];
endmodule

//--- dv/orlrs_device_monitor.sv
`timescale 1ns/10ps
module orlrs_device_monitor (
    // clock and reset
    input wire logic clock_in,
    input wire logic arst_n_in,
    // link
    input wire logic spi_sck_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_miso_out,
    input wire logic spi_miso_oe_out,
    // flags
    input wire logic prog_error_out,
    input wire logic freeze_out
);
    logic [7:0] sck_cnt_r, sck_cnt_nxt;
    logic [3:0] idle_r, idle_nxt;
    logic sck_d_r;

    // serial rises in this frame, clocks since deselect; both saturate so they never wrap
    always_comb begin
        sck_cnt_nxt = sck_cnt_r;
        idle_nxt = 4'h0;
        if (spi_cs_n_in) begin
            sck_cnt_nxt = 8'h00;
            idle_nxt = (idle_r == 4'hf) ? idle_r : idle_r + 4'h1;
        end else if (spi_sck_in && !sck_d_r && sck_cnt_r != 8'hff) begin
            sck_cnt_nxt = sck_cnt_r + 8'h01;
        end
    end

    // helper registers
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sck_cnt_r <= 8'h00;
            idle_r <= 4'h0;
            sck_d_r <= 1'b0;
        end else begin
            sck_cnt_r <= sck_cnt_nxt;
            idle_r <= idle_nxt;
            sck_d_r <= spi_sck_in;
        end
    end

    default clocking mon_cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);

    rst_flags_clear_a: assert property ($rose(arst_n_in) |-> !prog_error_out && !freeze_out)
        else $error("flags not clear at reset release");
    idle_flags_hold_a: assert property (idle_r >= 4'h8 |-> $stable(prog_error_out) && $stable(freeze_out))
        else $error("flag moved while deselected");
    idle_no_drive_a: assert property (idle_r >= 4'h4 |-> !spi_miso_oe_out)
        else $error("data out driven while deselected");
    drive_after_addr_a: assert property (spi_miso_oe_out && !spi_cs_n_in |-> sck_cnt_r >= 8'd32)
        else $error("data out driven before address done");
    read_bit_hold_a: assert property ($rose(spi_sck_in) && spi_miso_oe_out |=> $stable(spi_miso_out)[*3])
        else $error("read bit changed near rising edge");
    err_after_data_a: assert property ($rose(prog_error_out) |-> !spi_cs_n_in && sck_cnt_r >= 8'd40)
        else $error("error flag set outside a data byte");
    freeze_set_data_a: assert property ($rose(freeze_out) && !spi_cs_n_in |-> sck_cnt_r >= 8'd40 || sck_cnt_r == 8'd8)
        else $error("freeze set without a write");
    freeze_only_reset_a: assert property ($fell(freeze_out) |-> !spi_cs_n_in && sck_cnt_r == 8'd8)
        else $error("freeze cleared without a reset");
endmodule

//--- dv/orlrs_host_model.sv
`timescale 1ns/10ps
module orlrs_host_model (
    // clock and returned data
    input wire logic clock_in,
    input wire logic spi_miso_in,
    // link outputs
    output logic spi_sck_out,
    output logic spi_cs_n_out,
    output logic spi_mosi_out
);
    // idle link: clock still and low, device deselected
    initial begin
        spi_sck_out <= 1'b0;
        spi_cs_n_out <= 1'b1;
        spi_mosi_out <= 1'b0;
    end

    // one byte msb first; four clocks a half period gives 400 ns
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi_out <= tx[i];
            repeat (4) @(posedge clock_in);
            rx[i] = spi_miso_in;
            spi_sck_out <= 1'b1;
            repeat (4) @(posedge clock_in);
            spi_sck_out <= 1'b0;
        end
    endtask

    // whole frame; the gap after it covers the two-period minimum
    task automatic frame(input logic [7:0] cmd, input logic [23:0] adr, input bit addr_on,
                         input logic [7:0] wd, output logic [7:0] rd);
        logic [7:0] junk;
        rd = 8'h00;
        spi_cs_n_out <= 1'b0;
        repeat (4) @(posedge clock_in);
        shift(cmd, junk);
        if (addr_on) begin
            for (int b = 2; b >= 0; b--) begin
                shift(adr[8*b +: 8], junk);
            end
            shift(wd, rd);
        end
        repeat (8) @(posedge clock_in);
        spi_cs_n_out <= 1'b1;
        spi_mosi_out <= ~spi_mosi_out;
        repeat (20) @(posedge clock_in);
    endtask
endmodule

//--- dv/orlrs_device_tb_top.sv
`timescale 1ns/10ps
module orlrs_device_tb_top
    import orlrs_pkg::*;
;
    // clock, resets and link wires
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic factory_n_in = 1'b0;
    logic sck, cs_n, mosi, miso, miso_oe, prog_err, freeze;
    logic [7:0] rd_v;
    int mismatches = 0;
    int n_compared = 0;
    // delivered-erased bytes; reserved bytes are only ever read
    logic [23:0] ff_addr [6] = '{24'h10, 24'h13, 24'h14, 24'h1f, 24'h20, 24'h3ff};
    // shadow sequence on one register pair
    logic [7:0] rs_cmd [4] = '{CMD_REG_WRITE_NV, CMD_REG_WRITE_V, CMD_REG_PROG_OTP, CMD_SOFT_RESET};
    logic [7:0] rs_wd [4] = '{8'ha5, 8'h3c, 8'h0f, 8'h00};
    logic [7:0] rs_exp [4] = '{8'ha5, 8'h3c, 8'h0c, 8'h05};

    always #25 clock_in = ~clock_in;

    orlrs_device u_orlrs_device (
        .clock_in(clock_in), .arst_n_in(arst_n_in), .factory_n_in(factory_n_in),
        .spi_sck_in(sck), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
        .spi_miso_out(miso), .spi_miso_oe_out(miso_oe),
        .prog_error_out(prog_err), .freeze_out(freeze)
    );
    orlrs_host_model u_orlrs_host_model (
        .clock_in(clock_in), .spi_miso_in(miso),
        .spi_sck_out(sck), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi)
    );

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // one frame; clear and soft reset carry no address
    task automatic xf(input logic [7:0] cmd, input logic [23:0] adr, input logic [7:0] wd);
        u_orlrs_host_model.frame(cmd, adr, !(cmd == CMD_CLEAR_STATUS || cmd == CMD_SOFT_RESET), wd, rd_v);
    endtask

    // program, check error, read back, then clear the error
    task automatic prog_chk(input logic [23:0] adr, input logic [7:0] wd, input logic [7:0] exp, input logic err);
        xf(CMD_OTP_PROG, adr, wd);
        chk_flag(prog_err, err);
        xf(CMD_OTP_READ, adr, 8'hff);
        chk_byte(rd_v, exp);
        xf(CMD_CLEAR_STATUS, 24'h0, 8'h00);
    endtask

    initial begin
        repeat (2) @(posedge clock_in);
        factory_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        arst_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        chk_flag(prog_err, 1'b0);
        for (int i = 0; i < 16; i++) begin
            xf(CMD_OTP_READ, 24'(i), 8'hff);
            chk_byte(rd_v, RANDOM_DEFAULT[8*i +: 8]);
        end
        foreach (ff_addr[k]) begin
            xf(CMD_OTP_READ, ff_addr[k], 8'hff);
            chk_byte(rd_v, ERASED_BYTE);
        end
        chk_flag(miso_oe, 1'b0);
        // random bytes, region locks at both ends of the lock field
        prog_chk(24'h005, 8'hff, RANDOM_DEFAULT[47:40], 1'b0);
        prog_chk(24'h003, 8'h00, RANDOM_DEFAULT[31:24], 1'b1);
        prog_chk(24'h025, 8'h5a, 8'h5a, 1'b0);
        prog_chk(24'h010, 8'hfd, 8'hfd, 1'b0);
        prog_chk(24'h026, 8'h00, 8'hff, 1'b1);
        prog_chk(24'h040, 8'h33, 8'h33, 1'b0);
        prog_chk(24'h013, 8'h7f, 8'h7f, 1'b0);
        prog_chk(24'h3e0, 8'h00, 8'hff, 1'b1);
        prog_chk(24'h3df, 8'h81, 8'h81, 1'b0);
        // freeze until soft reset
        xf(CMD_REG_WRITE_V, {21'h0, REG_CR1}, 8'h01);
        chk_flag(freeze, 1'b1);
        prog_chk(24'h060, 8'h12, 8'hff, 1'b1);
        xf(CMD_SOFT_RESET, 24'h0, 8'h00);
        chk_flag(freeze, 1'b0);
        prog_chk(24'h060, 8'h12, 8'h12, 1'b0);
        foreach (rs_cmd[k]) begin
            xf(rs_cmd[k], {21'h0, REG_CR2}, rs_wd[k]);
            xf(CMD_REG_READ, {21'h0, REG_CR2}, 8'hff);
            chk_byte(rd_v, rs_exp[k]);
        end
        // volatile-only register keeps a write; status index ignores one
        xf(CMD_REG_WRITE_V, {21'h0, REG_STATUS_TWO_VOLATILE}, 8'h5a);
        xf(CMD_REG_READ, {21'h0, REG_STATUS_TWO_VOLATILE}, 8'hff);
        chk_byte(rd_v, 8'h5a);
        xf(CMD_REG_WRITE_NV, {21'h0, REG_ERROR_CORRECTION_STATUS}, 8'h99);
        xf(CMD_REG_READ, {21'h0, REG_ERROR_CORRECTION_STATUS}, 8'hff);
        chk_byte(rd_v, ERROR_CORRECTION_STATUS_VALUE);
        // device reset copies the stored copy, drops volatile-only writes
        xf(CMD_REG_WRITE_V, {21'h0, REG_CR4}, 8'h55);
        xf(CMD_REG_WRITE_NV, {21'h0, REG_CR1}, 8'h01);
        chk_flag(freeze, 1'b1);
        arst_n_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        arst_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        chk_flag(freeze, 1'b1);
        xf(CMD_REG_READ, {21'h0, REG_CR4}, 8'hff);
        chk_byte(rd_v, NV_DEFAULT);
        xf(CMD_REG_READ, {21'h0, REG_STATUS_TWO_VOLATILE}, 8'hff);
        chk_byte(rd_v, V_RESET);
        results();
    end

    // watchdog well beyond the expected run
    initial begin
        repeat (40000) @(posedge clock_in);
        mismatches++;
        results();
    end
endmodule

bind orlrs_device orlrs_device_monitor u_orlrs_device_monitor (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .spi_sck_in(spi_sck_in), .spi_cs_n_in(spi_cs_n_in),
    .spi_miso_out(spi_miso_out), .spi_miso_oe_out(spi_miso_oe_out),
    .prog_error_out(prog_error_out), .freeze_out(freeze_out)
);
